// >>> core/liu_gcr0_pkg.sv
// Constants and types for the line-interface global control register zero
// Functional notes
// [RL1] Bit 7: 0 dual rail, 1 single rail
// [RL2] Software also sets framer single-rail control
// [RL3] Bit 6: send all ones on loss
// [RL4] Bit 5: receive rails change rise/fall
// [RL5] Bit 4: transmit rails sampled fall/rise
// [RL6] Bit 3: data active high or low
// [RL7] Bit 2 has no function
// [RL8] Bit 1 clear blocks the interrupt pin
// [RL9] Interrupt also needs the source enable
// [RL10] Bit 0 held over 10us resets device
// [RL11] Soft reset keeps register bits unchanged
// [RL12] Loss after 175 or 4096 zeros
// [RL13] Bits reset to zero, unused reads zero
package liu_gcr0_pkg;

   // Control register layout, bit 7 first
   typedef struct packed {
      logic singleRail;
      logic autoAllOnes;
      logic rxEdge;
      logic txEdge;
      logic polarity;
      logic unused;
      logic intGate;
      logic swReset;
   } cfg_s;

   // One positive and one negative rail
   typedef struct packed {
      logic pos;
      logic neg;
   } rail_s;

   localparam logic [7:0] CTRL_RESET      = 8'h00;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hfb;

   // Loss-of-signal zero counts
   localparam int LOS_ZEROS_NORMAL   = 175;
   localparam int LOS_ZEROS_EXTENDED = 4096;
   localparam int LOS_COUNT_W        = 13;

   // Soft reset hold time, least time rounds up
   localparam int CLOCK_PERIOD_NS   = 25;
   localparam int RESET_HOLD_NS     = 10000;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int HOLD_COUNT_W      = 9;

endpackage

// >>> core/liu_global_control_zero.sv
// Line-interface global control register zero with its line-side logic
`timescale 1ns/1ps

module liu_global_control_zero
#(
   parameter int SOURCES = 4
)
(
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 lineClock,
   input  wire logic                 regWrite,
   input  wire liu_gcr0_pkg::cfg_s   regWriteData,
   output liu_gcr0_pkg::cfg_s        regReadData,
   input  wire logic                 extendedLossDetectEnable,
   input  wire logic [SOURCES-1:0]   sourceStatus,
   input  wire logic [SOURCES-1:0]   sourceEnable,
   output logic                      interruptRequest,
   output logic                      deviceReset,
   output logic                      receiveLossOfSignal,
   input  wire liu_gcr0_pkg::rail_s  lineRx,
   output liu_gcr0_pkg::rail_s       receiveRail,
   input  wire liu_gcr0_pkg::rail_s  transmitRail,
   output liu_gcr0_pkg::rail_s       lineTx
);
   import liu_gcr0_pkg::*;

   // Package counts cut to the counter widths
   localparam logic [HOLD_COUNT_W-1:0] HOLD_FULL = HOLD_COUNT_W'(RESET_HOLD_CYCLES);
   localparam logic [LOS_COUNT_W-1:0]  LOS_NORM  = LOS_COUNT_W'(LOS_ZEROS_NORMAL);
   localparam logic [LOS_COUNT_W-1:0]  LOS_EXT   = LOS_COUNT_W'(LOS_ZEROS_EXTENDED);

   // Elaboration checks: refuse a source count below one and sizes the counters cannot hold
   if (SOURCES < 1)
   begin : sourcesCheck
      $error("SOURCES must be at least one");
   end
   if (RESET_HOLD_CYCLES >= (1 << HOLD_COUNT_W))
   begin : holdCheck
      $error("Hold counter too narrow");
   end
   if (LOS_ZEROS_EXTENDED >= (1 << LOS_COUNT_W))
   begin : lossCheck
      $error("Loss counter too narrow");
   end

   // ==========================================================
   // Host clock domain state
   typedef struct packed {
      cfg_s                    ctrl;
      logic [HOLD_COUNT_W-1:0] holdCount;
      logic                    devReset;
      logic                    losMeta;
      logic                    losSync;
      logic                    irq;
   } sys_s;

   // ==========================================================
   // Line clock domain state
   typedef struct packed {
      cfg_s                   cfgMeta;
      cfg_s                   cfgSync;
      logic                   extMeta;
      logic                   extSync;
      logic                   rstMeta;
      logic                   rstSync;
      logic [LOS_COUNT_W-1:0] zeroCount;
      logic                   los;
      rail_s                  rxRise;
      rail_s                  txOut;
      logic                   amiMark;
   } link_s;

   sys_s  s;
   sys_s  next_s;
   link_s l;
   link_s next_l;
   rail_s rxFall;
   rail_s txFall;

   // Alternating mark coder; all-ones and single-rail transmit share it
   function automatic rail_s markFor(input logic negNext);
      rail_s mark;
      mark.pos = !negNext;
      mark.neg = negNext;
      return mark;
   endfunction

   // ==========================================================
   // Host side: register, soft reset timer, interrupt gate
   always_comb
   begin
      next_s = s;
      // [RL7] unused bit forced low
      if (regWrite)
         next_s.ctrl = cfg_s'(regWriteData & CTRL_WRITE_MASK);
      // [RL10] count how long bit 0 is held
      if (!s.ctrl.swReset)
         next_s.holdCount = '0;
      else if (s.holdCount != HOLD_FULL)
         next_s.holdCount = s.holdCount + 1'b1;
      // [RL10] reset once held past the limit
      next_s.devReset = s.ctrl.swReset && (s.holdCount == HOLD_FULL);
      // Loss flag into the host domain, two flops
      next_s.losMeta = l.los;
      next_s.losSync = s.losMeta;
      // [RL8] [RL9] global gate and per-source enable
      next_s.irq = s.ctrl.intGate && (|(sourceStatus & sourceEnable));
   end

   // Only power-up reset clears the register; soft reset never touches it
   always_ff @(posedge clock or posedge rst)
   begin
      // [RL13] all bits start at zero
      if (rst)
         s <= '{ctrl: cfg_s'(CTRL_RESET), default: '0};
      else
         s <= next_s;
   end

   // Host outputs come straight from flops
   assign regReadData         = s.ctrl;
   assign interruptRequest    = s.irq;
   assign deviceReset         = s.devReset;
   assign receiveLossOfSignal = s.losSync;

   // ==========================================================
   // Line side: loss detector, receive and transmit rails
   always_comb
   begin
      logic                   zero;
      logic [LOS_COUNT_W-1:0] limit;
      rail_s                  rxData;
      rail_s                  txData;
      zero   = 1'b0;
      limit  = '0;
      rxData = '0;
      txData = '0;
      next_l = l;
      // Two-flop crossings; config is quasi-static, so a write may show
      // a mixed word for one line cycle before it settles
      next_l.cfgMeta = s.ctrl;
      next_l.cfgSync = l.cfgMeta;
      next_l.extMeta = extendedLossDetectEnable;
      next_l.extSync = l.extMeta;
      next_l.rstMeta = s.devReset;
      next_l.rstSync = l.rstMeta;
      // [RL12] consecutive zeros on both rails
      zero  = !lineRx.pos && !lineRx.neg;
      limit = l.extSync ? LOS_EXT : LOS_NORM;
      if (!zero)
         next_l.zeroCount = '0;
      else if (l.zeroCount != LOS_EXT)
         next_l.zeroCount = l.zeroCount + 1'b1;
      next_l.los = next_l.zeroCount >= limit;
      // [RL1] single rail folds both rails onto one
      rxData = lineRx;
      if (l.cfgSync.singleRail)
         rxData = '{pos: lineRx.pos | lineRx.neg, neg: 1'b0};
      // [RL6] active-low option inverts output data
      if (l.cfgSync.polarity)
         rxData.pos = ~rxData.pos;
      if (l.cfgSync.polarity && !l.cfgSync.singleRail)
         rxData.neg = ~rxData.neg;
      next_l.rxRise = rxData;
      // [RL5] pick the sampling edge
      txData = l.cfgSync.txEdge ? transmitRail : txFall;
      // [RL6] active-low input data
      if (l.cfgSync.polarity)
         txData = ~txData;
      // [RL3] all ones replaces data during loss
      if (l.cfgSync.autoAllOnes && l.los)
      begin
         next_l.txOut   = markFor(l.amiMark);
         next_l.amiMark = ~l.amiMark;
      end
      // [RL1] single rail marks alternate polarity
      else if (l.cfgSync.singleRail)
      begin
         next_l.txOut = '0;
         if (txData.pos)
         begin
            next_l.txOut   = markFor(l.amiMark);
            next_l.amiMark = ~l.amiMark;
         end
      end
      else
         next_l.txOut = txData;
      // [RL11] soft reset clears line state only
      if (l.rstSync)
      begin
         next_l.zeroCount = '0;
         next_l.los       = 1'b0;
         next_l.rxRise    = '0;
         next_l.txOut     = '0;
         next_l.amiMark   = 1'b0;
      end
   end

   // Rising-edge line registers
   always_ff @(posedge lineClock or posedge rst)
   begin
      if (rst)
         l <= '0;
      else
         l <= next_l;
   end

   // Falling-edge copies for the edge-select options
   always_ff @(negedge lineClock or posedge rst)
   begin
      if (rst)
      begin
         rxFall <= '0;
         txFall <= '0;
      end
      else
      begin
         rxFall <= l.rxRise;
         txFall <= transmitRail;
      end
   end

   // [RL4] receive rails change on chosen edge
   assign receiveRail = l.cfgSync.rxEdge ? rxFall : l.rxRise;
   assign lineTx      = l.txOut;

   // ==========================================================
   // Checks
   // [RL8] gate low blocks interrupt
   a_gate_blocks_irq: assert property (@(posedge clock) disable iff (rst) // [RL8]
      !s.ctrl.intGate |=> !interruptRequest) else $error("irq with gate off");
   // [RL9] needs enabled source
   a_irq_needs_source: assert property (@(posedge clock) disable iff (rst) // [RL9]
      interruptRequest |-> $past(|(sourceStatus & sourceEnable)))
      else $error("irq without enabled source");
   // [RL10] reset only after full hold
   a_reset_after_hold: assert property (@(posedge clock) disable iff (rst) // [RL10]
      deviceReset |-> $past(s.holdCount) == HOLD_FULL && $past(s.ctrl.swReset))
      else $error("soft reset too early");
   // [RL11] register survives soft reset
   a_regs_survive: assert property (@(posedge clock) disable iff (rst) // [RL11]
      deviceReset && !regWrite |=> $stable(regReadData)) else $error("register lost");
   // [RL7] unused bit reads zero
   a_unused_zero: assert property (@(posedge clock) disable iff (rst) // [RL7]
      !regReadData.unused) else $error("unused bit set");
   // [RL12] loss needs enough zeros
   a_los_count: assert property (@(posedge lineClock) disable iff (rst) // [RL12]
      l.los && !l.extSync |-> l.zeroCount >= LOS_NORM) else $error("early loss");
   // [RL3] marks sent during loss
   a_all_ones: assert property (@(posedge lineClock) disable iff (rst) // [RL3]
      l.cfgSync.autoAllOnes && l.los && !l.rstSync |=> (lineTx.pos ^ lineTx.neg))
      else $error("no mark during loss");
   // [RL6] inverted receive data
   a_rx_polarity: assert property (@(posedge lineClock) disable iff (rst) // [RL6]
      l.cfgSync.polarity && !l.cfgSync.singleRail && !l.rstSync
      |=> l.rxRise == ~$past(lineRx)) else $error("polarity wrong");
   // [RL1] single rail leaves negative output idle
   a_single_rail: assert property (@(posedge lineClock) disable iff (rst) // [RL1]
      l.cfgSync.singleRail && !l.cfgSync.polarity |=> !l.rxRise.neg)
      else $error("negative rail active");
   // [RL5] rising sample passes through
   a_tx_rise: assert property (@(posedge lineClock) disable iff (rst) // [RL5]
      l.cfgSync.txEdge && l.cfgSync == $past(l.cfgSync) && !l.cfgSync.singleRail
      && !l.cfgSync.polarity && !l.cfgSync.autoAllOnes && !l.rstSync
      |=> lineTx == $past(transmitRail)) else $error("tx sample wrong");

   // [RL9] enabled source raises irq
   a_irq_follows: assert property (@(posedge clock) disable iff (rst) // [RL9]
      s.ctrl.intGate && (|(sourceStatus & sourceEnable)) |=> interruptRequest)
      else $error("irq missing for enabled source");
   // [RL10] reset drops with bit 0
   a_reset_needs_bit: assert property (@(posedge clock) disable iff (rst) // [RL10]
      !s.ctrl.swReset |=> !deviceReset) else $error("reset without bit 0");
   // [RL12] a one clears loss
   a_los_clears: assert property (@(posedge lineClock) disable iff (rst) // [RL12]
      (lineRx.pos || lineRx.neg) |=> !l.los)
      else $error("loss kept after a one");
   // [RL11] soft reset clears line state
   a_soft_reset_clears: assert property (@(posedge lineClock) disable iff (rst) // [RL11]
      l.rstSync |=> lineTx == '0 && !l.los)
      else $error("line state kept in soft reset");
   // [RL3] marks alternate during loss
   a_ami_alternates: assert property (@(posedge lineClock) disable iff (rst) // [RL3]
      (l.cfgSync.autoAllOnes && l.los && !l.rstSync) [*2] |=> lineTx != $past(lineTx))
      else $error("marks do not alternate");
   // [RL4] falling edge receive update
   a_rx_falling: assert property (@(negedge lineClock) disable iff (rst) // [RL4]
      l.cfgSync.rxEdge ##1 l.cfgSync.rxEdge |-> receiveRail == $past(l.rxRise))
      else $error("falling rail wrong");
   // [RL5] falling sample passes through
   a_tx_fall: assert property (@(posedge lineClock) disable iff (rst) // [RL5]
      !l.cfgSync.txEdge && l.cfgSync == $past(l.cfgSync) && !l.cfgSync.singleRail
      && !l.cfgSync.polarity && !l.cfgSync.autoAllOnes && !l.rstSync
      |=> lineTx == $past(txFall)) else $error("tx falling sample wrong");

   // Main scenarios the bench should reach
   c_soft_reset: cover property (@(posedge clock) disable iff (rst) $rose(deviceReset));
   c_loss: cover property (@(posedge lineClock) disable iff (rst) $rose(l.los));
   c_irq: cover property (@(posedge clock) disable iff (rst) $rose(interruptRequest));
   c_single_mark: cover property (@(posedge lineClock) disable iff (rst)
      l.cfgSync.singleRail && (lineTx.pos ^ lineTx.neg));
   c_rx_falling: cover property (@(negedge lineClock) disable iff (rst)
      l.cfgSync.rxEdge && receiveRail.pos);

endmodule

// >>> sim/line_partner.sv
// Line-side terminal model that drives the receive line and the transmit rails
`timescale 1ns/1ps

module line_partner
(
   input  wire logic                 lineClock,
   input  wire liu_gcr0_pkg::rail_s  rxWant,
   input  wire liu_gcr0_pkg::rail_s  txWant,
   output liu_gcr0_pkg::rail_s       lineRx,
   output liu_gcr0_pkg::rail_s       transmitRail
);
   import liu_gcr0_pkg::*;
   // ==========================================
   // Rail drive
   // Change just after the rising edge and hold a whole line cycle;
   // rails stay unknown only until the first line edge, inside reset
   always @(posedge lineClock)
   begin
      lineRx       <= rxWant;
      transmitRail <= txWant;
   end
endmodule

// >>> sim/tb.sv
// Self-checking bench for the line-interface global control register zero
`timescale 1ns/1ps

module tb;
   import liu_gcr0_pkg::*;
   logic       clock, rst, lineClock, regWrite, extendedLossDetectEnable;
   logic       interruptRequest, deviceReset, receiveLossOfSignal;
   cfg_s       regWriteData, regReadData;
   logic [3:0] sourceStatus, sourceEnable, st, en;
   rail_s      lineRx, receiveRail, transmitRail, lineTx, rxWant, txWant;
   int         err_count, cmp_count, seed, i;
   logic [7:0] v;
   // ==========================================
   // Design and line terminal
   liu_global_control_zero #(.SOURCES(4)) dut (.clock(clock), .rst(rst),
      .lineClock(lineClock), .regWrite(regWrite), .regWriteData(regWriteData),
      .regReadData(regReadData), .extendedLossDetectEnable(extendedLossDetectEnable),
      .sourceStatus(sourceStatus), .sourceEnable(sourceEnable),
      .interruptRequest(interruptRequest), .deviceReset(deviceReset),
      .receiveLossOfSignal(receiveLossOfSignal), .lineRx(lineRx),
      .receiveRail(receiveRail), .transmitRail(transmitRail), .lineTx(lineTx));
   line_partner partner (.lineClock(lineClock), .rxWant(rxWant), .txWant(txWant),
      .lineRx(lineRx), .transmitRail(transmitRail));
   // ==========================================
   // Clocks, the line clock at an unrelated phase
   initial
   begin
      clock = 0;
      forever #12.5 clock = ~clock;
   end
   initial
   begin
      lineClock = 0;
      #7;
      forever #62.5 lineClock = ~lineClock;
   end
   // ==========================================
   // Reference model of the receive rails
   function automatic logic [1:0] rxModel(input logic [7:0] c, input logic [1:0] r);
      logic [1:0] d;
      d = c[7] ? {r[1] | r[0], 1'b0} : r;
      return c[3] ? (c[7] ? d ^ 2'b10 : ~d) : d;
   endfunction
   // ==========================================
   // Shared tasks
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hostWait(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic regWr(input logic [7:0] d);
      @(posedge clock);
      regWrite     <= 1'b1;
      regWriteData <= d;
      @(posedge clock);
      regWrite     <= 1'b0;
      @(posedge clock);
   endtask
   // Bounded wait: sel 1 watches the device reset, 0 the loss flag
   task automatic waitBit(input int sel, input int lim);
      int k;
      for (k = 0; k < lim && (sel ? deviceReset : receiveLossOfSignal) !== 1'b1; k++)
         @(posedge clock);
      if (k == lim)
      begin
         err_count++;
         $display("wrong value at %0t: wait ran out", $time);
         end_sim();
      end
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      {rst, regWrite, extendedLossDetectEnable} = 3'b100;
      regWriteData = '0;
      sourceStatus = '0;
      sourceEnable = '0;
      rxWant       = '0;
      txWant       = '0;
      err_count    = 0;
      cmp_count    = 0;
      seed = 32'h659b1901;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      hostWait(2);
      check(regReadData, 8'h00);
      // Random writes, the unused bit always reads zero
      for (i = 0; i < 8; i++)
      begin
         v = 8'($random(seed));
         regWr(v);
         check(regReadData, v & 8'hfb);
      end
      // Interrupt gating over random sources and enables
      for (i = 0; i < 16; i++)
      begin
         st = 4'($random(seed));
         en = 4'($random(seed));
         regWr(i[0] ? 8'h02 : 8'h00);
         sourceStatus <= st;
         sourceEnable <= en;
         hostWait(3);
         check({7'h0, interruptRequest}, {7'h0, i[0] & |(st & en)});
      end
      // Rail formats, edges and polarity with settled random data
      for (i = 0; i < 16; i++)
      begin
         // Single rail here also stands for the framer's own format control
         v = {i[0], 1'b0, i[1], i[2], i[3], 3'h0};
         regWr(v);
         rxWant <= rail_s'(2'($random(seed)));
         txWant <= rail_s'(2'($random(seed)));
         hostWait(45);
         check({6'h0, receiveRail}, {6'h0, rxModel(v, rxWant)});
         if (!v[7])
            check({6'h0, lineTx}, {6'h0, txWant ^ {v[3], v[3]}});
         else
            check({7'h0, lineTx.pos ^ lineTx.neg}, {7'h0, txWant.pos ^ v[3]});
      end
      // Loss thresholds, then all ones on the line while lost
      regWr(8'h40);
      extendedLossDetectEnable <= 1'b1;
      rxWant <= 2'b00;
      hostWait(1500);
      check({7'h0, receiveLossOfSignal}, 8'h00);
      rxWant <= 2'b10;
      hostWait(20);
      extendedLossDetectEnable <= 1'b0;
      rxWant <= 2'b00;
      hostWait(700);
      check({7'h0, receiveLossOfSignal}, 8'h00);
      waitBit(0, 600);
      hostWait(15);
      check({7'h0, lineTx.pos ^ lineTx.neg}, 8'h01);
      // Ones held on the positive rail clear the loss flag again
      rxWant <= 2'b10;
      txWant <= 2'b11;
      hostWait(30);
      check({7'h0, receiveLossOfSignal}, 8'h00);
      // Software reset held past the minimum time, line state cleared
      regWr(8'h01);
      hostWait(RESET_HOLD_CYCLES - 1);
      check({7'h0, deviceReset}, 8'h00);
      waitBit(1, 200);
      check(regReadData, 8'h01);
      hostWait(40);
      check({6'h0, lineTx}, 8'h00);
      check({6'h0, receiveRail}, 8'h00);
      // Reset output falls one cycle after the clearing write lands
      regWr(8'h00);
      hostWait(1);
      check({7'h0, deviceReset}, 8'h00);
      end_sim();
   end
endmodule
